/* File: bench/abb_bus_master_chk.sv */
// port-level checker for the backplane bus master
`timescale 1ns/100ps
`default_nettype none
module abb_bus_master_chk #(
    parameter int TIMEOUT_CYC = 1000
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic [abb_pkg::ADDR_W-1:0] dalOut,
    input  wire logic [abb_pkg::ADDR_W-1:0] dalOe,
    input  wire logic                       ioPageOe,
    input  wire logic                       cycleSyncOe,
    input  wire logic                       cycleSyncOut,
    input  wire logic                       inStrobeOe,
    input  wire logic                       outStrobeOe,
    input  wire logic                       writeByteOe,
    input  wire logic                       slaveReplyIn,
    input  wire logic                       dmaReqOe,
    input  wire logic                       dmaSelAckOe,
    input  wire logic                       dmaGrantIn,
    input  wire logic                       intAckIn,
    input  wire logic                       intAckOut,
    input  wire logic                       rspValid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // strobe wait counter, bounded by the timeout
    logic [15:0] waitCnt_ff;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !(inStrobeOe | outStrobeOe) || !slaveReplyIn)
            waitCnt_ff <= '0;
        else
            waitCnt_ff <= waitCnt_ff + 16'h0001;
    end
    sequence syncStart; $rose(cycleSyncOe); endsequence
    sequence syncEnd; $fell(cycleSyncOe); endsequence
    // ==========================================================
    // assertions
    timeout_bound_a: assert property (waitCnt_ff <= TIMEOUT_CYC + 1)
        else $error("strobe waited past the timeout");
    master_only_a: assert property (cycleSyncOe |-> dmaSelAckOe)
        else $error("sync driven without mastership");
    one_strobe_a: assert property (!(inStrobeOe && outStrobeOe))
        else $error("both strobes asserted");
    low_drive_a: assert property (dalOut == '0 && !cycleSyncOut)
        else $error("line driven high");
    addr_setup_a: assert property (syncStart |-> $past({dalOe, ioPageOe, writeByteOe}, 8)
        == {dalOe, ioPageOe, writeByteOe}) else $error("address setup too short");
    addr_hold_a: assert property (syncStart |-> $stable(dalOe) [*3])
        else $error("address hold too short");
    strobe_delay_a: assert property ($rose(inStrobeOe | outStrobeOe) |-> $past(cycleSyncOe, 10))
        else $error("strobe too soon after sync");
    sync_release_a: assert property (syncEnd |-> $past(slaveReplyIn))
        else $error("sync negated while reply asserted");
    cycle_gap_a: assert property (syncEnd |-> ##[29:31] rspValid)
        else $error("gap after sync wrong");
    dma_drop_a: assert property (dmaReqOe && !dmaGrantIn |=> !dmaReqOe)
        else $error("request kept after grant");
    ack_pass_a: assert property (intAckOut == $past(intAckIn))
        else $error("acknowledge not passed on");
endmodule
bind abb_bus_master abb_bus_master_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.*);
`default_nettype wire

/* File: bench/abb_bus_master_tb_top.sv */
// testbench for the backplane bus master
`timescale 1ns/100ps
`default_nettype none
module abb_bus_master_tb_top;
    // ==========================================================
    // signals; short timeout keeps the abort case quick
    localparam int TMO = 50;
    logic        clk_sys, nrst, reqValid, reqWrite, reqByte, reqIoPage, intAckIn;
    logic        noRply, par, busInitIn, reqReady, rspValid, rspParErr, rspTimeout;
    logic [21:0] reqAddr, dalOut, dalOe, mDal, addrSeen;
    wire  [21:0] dalIn;
    logic [15:0] reqWdata, rspRdata;
    logic [7:0]  dly;
    logic        wbSeen;
    logic        ioPageOut, ioPageOe, cycleSyncOut, cycleSyncOe, inStrobeOut, inStrobeOe;
    logic        outStrobeOut, outStrobeOe, writeByteOut, writeByteOe, dmaReqOut, dmaReqOe;
    logic        dmaSelAckOut, dmaSelAckOe, dmaGrantOut, intAckOut, slaveReplyIn, dmaGrantIn;
    wire         cycleSyncIn;
    int          bad_count, total_checks, n;
    // wire levels: low while any party pulls the line
    assign dalIn       = ~(dalOe | mDal);
    assign cycleSyncIn = ~cycleSyncOe;
    abb_bus_master #(.TIMEOUT_CYC(TMO)) dut (.*);
    abb_slave_model model (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // the acknowledge chain toggles so the pass-on is seen
    always @(posedge clk_sys)
        if (nrst) intAckIn <= ~intAckIn;
    // write/byte level seen while the output strobe stands
    always @(posedge clk_sys)
        if (outStrobeOe) wbSeen <= writeByteOe;
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one command, held until taken, then bounded wait for the answer
    task automatic cmd(logic w, logic io, logic [21:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reqValid <= 1'b1; reqWrite <= w; reqIoPage <= io; reqAddr <= a; reqWdata <= d;
        do @(negedge clk_sys); while (reqReady !== 1'b1);
        @(posedge clk_sys);
        reqValid <= 1'b0;
        for (n = 0; n < 3000 && rspValid !== 1'b1; n++) @(negedge clk_sys);
        check("rsp seen", rspValid, 1'b1);
    endtask
    task automatic t_wr_rd();
        cmd(1'b1, 1'b0, 22'h3F_FFFE, 16'hA55A);
        check("wr addr", addrSeen, 22'h3F_FFFE);
        check("wb word", wbSeen, 1'b0);
        cmd(1'b0, 1'b1, 22'h00_1000, 16'h0000);
        check("rd addr", addrSeen, 22'h00_1000);
        check("rd data", rspRdata, 16'hA55A);
        check("no tmo", rspTimeout, 1'b0);
    endtask
    task automatic t_slow_par();
        dly = 8'd40; par = 1'b1;
        cmd(1'b0, 1'b0, 22'h20_0002, 16'h0000);
        check("slow ok", rspTimeout, 1'b0);
        check("par err", rspParErr, 1'b1);
        dly = 8'd0; par = 1'b0;
    endtask
    task automatic t_timeout();
        noRply = 1'b1;
        cmd(1'b0, 1'b0, 22'h15_5554, 16'h0000);
        check("tmo set", rspTimeout, 1'b1);
        check("tmo span", n >= TMO && n < TMO + 120, 1'b1);
        noRply = 1'b0;
        cmd(1'b1, 1'b0, 22'h0A_AAAA, 16'h1234);
        check("tmo clr", rspTimeout, 1'b0);
        check("wr2 addr", addrSeen, 22'h0A_AAAA);
    endtask
    // byte write, then a cycle cut by bus init, then a reset in mid-run
    task automatic t_byte_init();
        reqByte <= 1'b1;
        cmd(1'b1, 1'b0, 22'h00_0001, 16'h5A00);
        check("wb byte", wbSeen, 1'b1);
        reqByte <= 1'b0;
        noRply <= 1'b1;
        @(posedge clk_sys);
        reqValid <= 1'b1; reqWrite <= 1'b0; reqIoPage <= 1'b0; reqAddr <= 22'h00_0100;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        repeat (30) @(posedge clk_sys);
        @(negedge clk_sys);
        check("sync held", cycleSyncOe, 1'b1);
        check("grant kept", dmaGrantOut, 1'b1);
        @(posedge clk_sys);
        busInitIn <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("init sync", cycleSyncOe, 1'b0);
        check("init ready", reqReady, 1'b0);
        busInitIn <= 1'b1;
        noRply <= 1'b0;
        @(negedge clk_sys);
        check("init idle", reqReady, 1'b1);
        check("init no rsp", rspValid, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        check("rst ready", reqReady, 1'b1);
        check("rst sack", dmaSelAckOe, 1'b0);
        cmd(1'b1, 1'b0, 22'h00_0200, 16'hC33C);
        check("rst wr addr", addrSeen, 22'h00_0200);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        nrst = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; reqByte = 1'b0; reqIoPage = 1'b0;
        reqAddr = '0; reqWdata = '0; intAckIn = 1'b1; busInitIn = 1'b1;
        noRply = 1'b0; par = 1'b0; dly = 8'd0; bad_count = 0; total_checks = 0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        t_wr_rd();
        t_slow_par();
        t_timeout();
        t_byte_init();
        finish_test();
    end
    // watchdog well beyond eight commands
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire

/* File: bench/abb_slave_model.sv */
// far side model: processor arbiter and one memory slave
`timescale 1ns/100ps
`default_nettype none
module abb_slave_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [21:0] dalIn,
    input  wire logic        cycleSyncIn,
    input  wire logic        inStrobeOe,
    input  wire logic        outStrobeOe,
    input  wire logic        dmaReqOe,
    input  wire logic        noRply,
    input  wire logic        par,
    input  wire logic [7:0]  dly,
    output logic             slaveReplyIn,
    output logic             dmaGrantIn,
    output logic [21:0]      mDal,
    output logic [21:0]      addrSeen
);
    // ==========================================================
    // slave state
    logic [7:0]  cnt_ff;
    logic [15:0] mem_ff;
    logic        stb;
    assign stb = inStrobeOe | outStrobeOe;
    // reply after dly cycles; noRply leaves the master to time out
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            slaveReplyIn <= 1'b1;
            dmaGrantIn   <= 1'b1;
            mDal         <= '0;
            cnt_ff       <= '0;
        end
        else
        begin
            dmaGrantIn <= ~dmaReqOe;
            if ($fell(cycleSyncIn))
                addrSeen <= ~dalIn;
            if (stb)
            begin
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == dly && !noRply)
                begin
                    slaveReplyIn <= 1'b0;
                    if (outStrobeOe)
                        mem_ff <= ~dalIn[15:0];
                    else
                        mDal <= {5'h00, par, mem_ff};
                end
            end
            else
            begin
                // released lines go back to the terminated level
                cnt_ff       <= '0;
                slaveReplyIn <= 1'b1;
                mDal         <= '0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/abb_bus_master.sv */
// interlocked backplane bus master with dma arbitration and reply timeout
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1: abort cycle when slave silent 10 us
// R2: timeout longer than slowest slave reply
// R3: drive master lines only while bus master
// R4: wait slave reply before finishing transfer
// R5: master starts, slave replies with data
// R6: progress only by reply handshake levels
// R7: processor grants mastership, we request it
// R8: pass grant/acknowledge on if not ours
// R9: 22 address lines, 16 carry data
// R10: drive transfer, chain and dma lines
// R11: always issue full 22-bit address
// R12: lines active low, assert by pulling
// R13: start only as master, sync negated
// R14: write/byte asserted at address means write
// R15: count cycles from strobe, flag timeout
module abb_bus_master #(
    parameter int TIMEOUT_CYC = abb_pkg::TIMEOUT_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    // user command side
    input  wire logic                       reqValid,
    output logic                            reqReady,
    input  wire logic                       reqWrite,
    input  wire logic                       reqByte,
    input  wire logic                       reqIoPage,
    input  wire logic [abb_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic [abb_pkg::DATA_W-1:0] reqWdata,
    output logic                            rspValid,
    output logic [abb_pkg::DATA_W-1:0]      rspRdata,
    output logic                            rspParErr,
    output logic                            rspTimeout,
    // bus lines: In is wire level, Out the driven level, Oe high while driving
    input  wire logic [abb_pkg::ADDR_W-1:0] dalIn,
    output logic [abb_pkg::ADDR_W-1:0]      dalOut,
    output logic [abb_pkg::ADDR_W-1:0]      dalOe,
    output logic                            ioPageOut,
    output logic                            ioPageOe,
    output logic                            cycleSyncOut,
    output logic                            cycleSyncOe,
    input  wire logic                       cycleSyncIn,
    output logic                            inStrobeOut,
    output logic                            inStrobeOe,
    output logic                            outStrobeOut,
    output logic                            outStrobeOe,
    output logic                            writeByteOut,
    output logic                            writeByteOe,
    input  wire logic                       slaveReplyIn,
    input  wire logic                       busInitIn,
    output logic                            dmaReqOut,
    output logic                            dmaReqOe,
    output logic                            dmaSelAckOut,
    output logic                            dmaSelAckOe,
    input  wire logic                       dmaGrantIn,
    output logic                            dmaGrantOut,
    input  wire logic                       intAckIn,
    output logic                            intAckOut
);

    // ==========================================================
    // counts typed at counter width
    localparam int CW = abb_pkg::CNT_W;
    localparam logic [CW-1:0] CNT_ZERO   = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE    = 16'h0001;
    localparam logic [CW-1:0] SETUP_LAST = CW'(abb_pkg::ADDR_SETUP_CYC - 1);
    localparam logic [CW-1:0] HOLD_LAST  = CW'(abb_pkg::ADDR_HOLD_CYC - 1);
    localparam logic [CW-1:0] DSET_LAST  = CW'(abb_pkg::STROBE_DLY_CYC - abb_pkg::ADDR_HOLD_CYC - 1);
    localparam logic [CW-1:0] DESK_LAST  = CW'(abb_pkg::DESKEW_CYC - 1);
    localparam logic [CW-1:0] GAP_LAST   = CW'(abb_pkg::GAP_CYC - 1);
    localparam logic [CW-1:0] TMO_LAST   = CW'(TIMEOUT_CYC - 1);
    localparam logic          PULL_LOW   = 1'b0;
    localparam logic [abb_pkg::ADDR_W-1:0] DAL_NONE = 22'h00_0000;
    localparam logic [abb_pkg::DATA_W-1:0] DATA_NONE = 16'h0000;

    abb_pkg::abb_state_t stateFf;
    abb_pkg::abb_state_t nxt_state;
    logic [CW-1:0]                 cntFf;
    logic [CW-1:0]                 nxt_cnt;
    logic [abb_pkg::ADDR_W-1:0]    addrFf;
    logic [abb_pkg::DATA_W-1:0]    wdataFf;
    logic                          writeFf;
    logic                          byteFf;
    logic                          ioFf;
    logic [abb_pkg::DATA_W-1:0]    rdataFf;
    logic                          parFf;
    logic                          tmoFf;
    logic                          rspValidFf;
    logic                          grantOutFf;
    logic                          intAckOutFf;

    // ==========================================================
    // received levels turned into asserted flags
    wire replyAct  = ~slaveReplyIn;   // R12
    wire syncAct   = ~cycleSyncIn;
    wire grantAct  = ~dmaGrantIn;
    wire initAct   = ~busInitIn;
    wire accept    = reqValid & reqReady;

    // phase decode of the registered state
    wire inAddr    = (stateFf == abb_pkg::ST_ADDR);
    wire inHold    = (stateFf == abb_pkg::ST_SYNC);
    wire inData    = (stateFf == abb_pkg::ST_DSET) | (stateFf == abb_pkg::ST_STROBE);
    wire inStrobe  = (stateFf == abb_pkg::ST_STROBE) | (stateFf == abb_pkg::ST_DESKEW);
    wire inCycle   = inHold | inData | inStrobe | (stateFf == abb_pkg::ST_RELEASE);
    wire ownBus    = (stateFf != abb_pkg::ST_IDLE) & (stateFf != abb_pkg::ST_ARB_REQ);
    wire busQuiet  = ~syncAct & ~replyAct;
    wire timedOut  = (cntFf == TMO_LAST);                  // R15

    // ==========================================================
    // sequencer: the strobe and release steps wait on the slave's reply level, or the timeout
    always_comb
    begin
        nxt_state = stateFf;
        unique case (stateFf)
            abb_pkg::ST_IDLE:
                if (accept)
                    nxt_state = abb_pkg::ST_ARB_REQ;       // R5
            abb_pkg::ST_ARB_REQ:
                if (grantAct)
                    nxt_state = abb_pkg::ST_ARB_ACK;       // R7
            abb_pkg::ST_ARB_ACK:
                if (busQuiet)
                    nxt_state = abb_pkg::ST_ADDR;          // R13
            abb_pkg::ST_ADDR:
                if (cntFf == SETUP_LAST)
                    nxt_state = abb_pkg::ST_SYNC;
            abb_pkg::ST_SYNC:
                if (cntFf == HOLD_LAST)
                    nxt_state = abb_pkg::ST_DSET;
            abb_pkg::ST_DSET:
                if (cntFf == DSET_LAST)
                    nxt_state = abb_pkg::ST_STROBE;
            abb_pkg::ST_STROBE:
                if (replyAct)
                    nxt_state = writeFf ? abb_pkg::ST_RELEASE : abb_pkg::ST_DESKEW; // R4 R6
                else if (timedOut)
                    nxt_state = abb_pkg::ST_END;           // R1 R2
            abb_pkg::ST_DESKEW:
                if (cntFf == DESK_LAST)
                    nxt_state = abb_pkg::ST_RELEASE;
            abb_pkg::ST_RELEASE:
                if (~replyAct | timedOut)
                    nxt_state = abb_pkg::ST_END;           // R6
            abb_pkg::ST_END:
                if (cntFf == GAP_LAST)
                    nxt_state = abb_pkg::ST_IDLE;
        endcase
        if (initAct)
            nxt_state = abb_pkg::ST_IDLE;                  // bus init abandons the cycle
    end

    // phase counter restarts on every state change, saturates at the top
    assign nxt_cnt = (nxt_state != stateFf) ? CNT_ZERO :
                     (&cntFf)               ? cntFf    : cntFf + CNT_ONE;

    // ==========================================================
    // state and counter
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            stateFf <= abb_pkg::ST_IDLE;
            cntFf   <= CNT_ZERO;
        end
        else
        begin
            stateFf <= nxt_state;
            cntFf   <= nxt_cnt;
        end
    end

    // request fields latched on acceptance, held for the whole cycle
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            addrFf  <= DAL_NONE;
            wdataFf <= DATA_NONE;
            writeFf <= 1'b0;
            byteFf  <= 1'b0;
            ioFf    <= 1'b0;
        end
        else if (accept)
        begin
            addrFf  <= reqAddr;                            // R11
            wdataFf <= reqWdata;
            writeFf <= reqWrite;
            byteFf  <= reqWrite & reqByte;
            ioFf    <= reqIoPage;
        end
    end

    // read data taken after the deskew wait, sampled inverted since lines are low-true
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rdataFf <= DATA_NONE;
            parFf   <= 1'b0;
        end
        else if ((stateFf == abb_pkg::ST_DESKEW) && (cntFf == DESK_LAST))
        begin
            rdataFf <= ~dalIn[abb_pkg::DATA_W-1:0];        // R9
            parFf   <= ~dalIn[abb_pkg::PAR_BIT];
        end
    end

    // timeout flag set on abort, cleared when a new cycle is accepted
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            tmoFf <= 1'b0;
        else if (accept)
            tmoFf <= 1'b0;
        else if (((stateFf == abb_pkg::ST_STROBE) && !replyAct && timedOut) ||
                 ((stateFf == abb_pkg::ST_RELEASE) && replyAct && timedOut))
            tmoFf <= 1'b1;                                 // R15
    end

    // one-cycle answer when the gap after the cycle has run out
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            rspValidFf <= 1'b0;
        else
            rspValidFf <= (stateFf == abb_pkg::ST_END) && (cntFf == GAP_LAST) && !initAct;
    end

    // ==========================================================
    // chains: we never take interrupts, and pass a grant on only while idle
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            grantOutFf  <= 1'b1;
            intAckOutFf <= 1'b1;
        end
        else
        begin
            grantOutFf  <= ~(grantAct & (stateFf == abb_pkg::ST_IDLE));    // R8
            intAckOutFf <= intAckIn;                                        // R8
        end
    end

    // ==========================================================
    // user side answers
    assign reqReady   = (stateFf == abb_pkg::ST_IDLE) & ~initAct;
    assign rspValid   = rspValidFf;
    assign rspRdata   = rdataFf;
    assign rspParErr  = parFf;
    assign rspTimeout = tmoFf;

    // ==========================================================
    // open-collector drives: each Out with an Oe is always low, Oe marks an asserted line;
    // releasing a line lets the termination pull it negated
    assign dalOut       = {abb_pkg::ADDR_W{PULL_LOW}};                      // R12
    assign dalOe        = (inAddr | inHold)     ? addrFf :                  // R9 R11
                          (inData & writeFf)    ? {{(abb_pkg::ADDR_W-abb_pkg::DATA_W){1'b0}}, wdataFf} :
                                                  DAL_NONE;
    assign ioPageOut    = PULL_LOW;
    assign ioPageOe     = (inAddr | inHold) & ioFf;
    assign cycleSyncOut = PULL_LOW;
    assign cycleSyncOe  = inCycle & ownBus;                                 // R3
    assign inStrobeOut  = PULL_LOW;
    assign inStrobeOe   = inStrobe & ~writeFf;                              // R5
    assign outStrobeOut = PULL_LOW;
    assign outStrobeOe  = (stateFf == abb_pkg::ST_STROBE) & writeFf;        // R5
    assign writeByteOut = PULL_LOW;
    assign writeByteOe  = ((inAddr | inHold) & writeFf) |                   // R14
                          ((inData | (stateFf == abb_pkg::ST_RELEASE)) & byteFf);
    assign dmaReqOut    = PULL_LOW;
    assign dmaReqOe     = (stateFf == abb_pkg::ST_ARB_REQ);                 // R7
    assign dmaSelAckOut = PULL_LOW;
    assign dmaSelAckOe  = ownBus;                                           // R3 R10
    assign dmaGrantOut  = grantOutFf;
    assign intAckOut    = intAckOutFf;

endmodule
`default_nettype wire

/* File: pkg/abb_pkg.sv */
// constants, timing figures and state codes of the backplane bus master
`default_nettype none
package abb_pkg;

    // ==========================================================
    // widths and field positions
    localparam int ADDR_W       = 22;   // full physical address path
    localparam int DATA_W       = 16;   // muxed data/address lines
    localparam int PAR_BIT      = 16;   // parity error flag line on reads
    localparam int CNT_W        = 16;   // phase counter width
    localparam int CLK_MHZ      = 100;  // clk_sys rate

    // ==========================================================
    // bus timing figures in their own units
    localparam int ADDR_SETUP_NS = 75;  // address/control before sync
    localparam int ADDR_HOLD_NS  = 25;  // address kept after sync
    localparam int STROBE_DLY_NS = 100; // sync to data strobe
    localparam int DESKEW_NS     = 200; // reply to read data capture
    localparam int SYNC_GAP_NS   = 200; // sync negated before next cycle
    localparam int REPLY_GAP_NS  = 300; // reply negation to next sync
    localparam int TIMEOUT_US    = 10;  // slave reply timeout

    // least times round up, never below one cycle
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // larger of two cycle counts
    function automatic int maxcyc(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int ADDR_SETUP_CYC = ns2cyc(ADDR_SETUP_NS);
    localparam int ADDR_HOLD_CYC  = ns2cyc(ADDR_HOLD_NS);
    localparam int STROBE_DLY_CYC = ns2cyc(STROBE_DLY_NS);
    localparam int DESKEW_CYC     = ns2cyc(DESKEW_NS);
    localparam int GAP_CYC        = maxcyc(ns2cyc(SYNC_GAP_NS), ns2cyc(REPLY_GAP_NS));
    // longest time rounds down
    localparam int TIMEOUT_CYC    = (TIMEOUT_US * 1000 * CLK_MHZ) / 1000;

    // ==========================================================
    // master sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_ARB_REQ = 10'h002,
        ST_ARB_ACK = 10'h004,
        ST_ADDR    = 10'h008,
        ST_SYNC    = 10'h010,
        ST_DSET    = 10'h020,
        ST_STROBE  = 10'h040,
        ST_DESKEW  = 10'h080,
        ST_RELEASE = 10'h100,
        ST_END     = 10'h200
    } abb_state_t;

endpackage
`default_nettype wire
